// ### fsps_sequencer.sv
`timescale 1ns/10ps
module fsps_sequencer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic soft_rstn,
    input wire logic serial_prog_mode,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [1:0] sfr_sel,
    input wire logic [1:0] sfr_be,
    input wire logic [15:0] sfr_wdata,
    output logic [15:0] sfr_rdata,
    input wire logic tbl_req,
    input wire logic tbl_write,
    input wire logic tbl_high,
    input wire logic tbl_byte,
    input wire logic [15:0] tbl_ea,
    input wire logic [15:0] tbl_wdata,
    output logic [15:0] tbl_rdata,
    output logic tbl_done,
    output logic [23:0] fl_raddr,
    input wire logic [23:0] fl_rdata,
    output logic fl_req,
    output fsps_pkg::fsps_fcmd_t fl_cmd,
    output logic [23:0] fl_addr,
    output logic [23:0] fl_wdata,
    input wire logic fl_ack,
    output logic cpu_stall
);
    import fsps_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SINGLE = 2'b01,
        ST_ROW = 2'b10
    } fsps_state_t;

    typedef enum logic [1:0] {
        KEY_NONE = 2'b00,
        KEY_HALF = 2'b01,
        KEY_OPEN = 2'b10
    } fsps_key_t;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic fsps_fcmd_t decode_op(input logic erase, input logic [3:0] op,
                                             input logic serial);
        fsps_fcmd_t c;
        c = FCMD_NONE;
        case (op)
            OP_WORD_PROG: c = erase ? FCMD_NONE : FCMD_WORD_PROG;
            OP_ROW_PROG: c = erase ? FCMD_NONE : FCMD_WORD_PROG;
            OP_PAGE_ERASE: c = erase ? FCMD_PAGE_ERASE : FCMD_NONE;
            OP_BULK_ERASE: c = (erase && serial) ? FCMD_BULK_ERASE : FCMD_NONE;
            default: c = FCMD_NONE;
        endcase
        return c;
    endfunction : decode_op

    function automatic logic [2:0] lane_mask(input logic high, input logic byte_m,
                                             input logic sel);
        logic [2:0] m;
        m = BE_NONE;
        if (!high) begin
            m = byte_m ? (sel ? BE_BYTE1 : BE_BYTE0) : BE_LOW_WORD;
        end else begin
            m = (byte_m && sel) ? BE_NONE : BE_BYTE2;
        end
        return m;
    endfunction : lane_mask

    // ----------------------------------------------------------------
    // Serial mode pin synchroniser
    // ----------------------------------------------------------------
    logic ser_s1_r;
    logic ser_s2_r;
    logic ser_s3_r;
    logic ser_mode_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ser_s1_r <= 1'b0;
            ser_s2_r <= 1'b0;
            ser_s3_r <= 1'b0;
            ser_mode_r <= 1'b0;
        end else begin
            ser_s1_r <= serial_prog_mode;
            ser_s2_r <= ser_s1_r;
            ser_s3_r <= ser_s2_r;
            if (ser_s2_r == ser_s3_r) begin
                ser_mode_r <= ser_s3_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers and state
    // ----------------------------------------------------------------
    logic start_r;
    logic op_write_enable_r;
    logic err_r;
    logic erase_r;
    logic [3:0] op_r;
    logic [7:0] page_r;
    fsps_key_t key_r;
    fsps_state_t state_r;
    logic [ADDR_W-1:0] tgt_r;
    logic [ADDR_W-1:0] base_r;
    logic [1:0] tcnt_r;
    logic t_wr_r;
    logic t_high_r;
    logic t_byte_r;
    logic [15:0] t_wdata_r;
    logic [IDX_W-1:0] idx_r;
    logic [IDX_W-1:0] idx_last_r;
    fsps_fcmd_t cmd_r;
    logic tbl_done_r;
    logic [15:0] tbl_rdata_r;
    logic [15:0] sfr_rdata_r;

    logic ctl_wr;
    logic start_try;
    logic key_ok;
    fsps_fcmd_t start_cmd;
    logic tbl_take;
    logic tbl_end;
    logic [15:0] ctl_view;

    fsps_latch_if lat ();

    fsps_latch_buf u_latch (
        .clk(clk),
        .lat(lat)
    );

    assign ctl_wr = sfr_wr && (sfr_sel == SFR_CTL);
    assign start_try = ctl_wr && sfr_be[1] && sfr_wdata[CTL_START_BIT] && !start_r;
    assign key_ok = (key_r == KEY_OPEN) && op_write_enable_r;
    assign start_cmd = decode_op(erase_r, op_r, ser_mode_r);
    assign tbl_take = tbl_req && (tcnt_r == 2'h0) && (state_r == ST_IDLE);
    assign tbl_end = (tcnt_r == 2'(TBL_CYCLES));
    assign cpu_stall = (state_r != ST_IDLE);
    assign ctl_view = {start_r, op_write_enable_r, err_r, 6'h00, erase_r, 2'h0, op_r};

    // ----------------------------------------------------------------
    // Control register, power-on reset only
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            op_write_enable_r <= 1'b0;
            erase_r <= 1'b0;
            op_r <= 4'h0;
        end else if (ctl_wr && !cpu_stall) begin
            if (sfr_be[1]) begin
                op_write_enable_r <= sfr_wdata[CTL_OP_WRITE_ENABLE_BIT];
            end
            if (sfr_be[0]) begin
                erase_r <= sfr_wdata[CTL_ERASE_BIT];
                op_r <= sfr_wdata[CTL_OP_LSB +: CTL_OP_W];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            start_r <= 1'b0;
        end else if (start_try && key_ok && (start_cmd != FCMD_NONE)) begin
            start_r <= 1'b1;
        end else if (state_r != ST_IDLE && fl_ack &&
                     (state_r == ST_SINGLE || idx_r == idx_last_r)) begin
            start_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            err_r <= 1'b0;
        end else if (start_try && !key_ok) begin
            err_r <= 1'b1;
        end else if (start_try && start_cmd != FCMD_NONE) begin
            err_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Unlock key tracking
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            key_r <= KEY_NONE;
        end else if (!soft_rstn) begin
            key_r <= KEY_NONE;
        end else if (sfr_wr && sfr_sel == SFR_KEY) begin
            if (sfr_wdata[7:0] == KEY_FIRST) begin
                key_r <= KEY_HALF;
            end else if (key_r == KEY_HALF && sfr_wdata[7:0] == KEY_SECOND) begin
                key_r <= KEY_OPEN;
            end else begin
                key_r <= KEY_NONE;
            end
        end else if (sfr_wr || tbl_take) begin
            key_r <= KEY_NONE;
        end
    end

    // ----------------------------------------------------------------
    // Page register and register reads
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            page_r <= 8'h00;
        end else if (sfr_wr && sfr_sel == SFR_PAGE && sfr_be[0]) begin
            page_r <= sfr_wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata_r <= 16'h0000;
        end else if (sfr_rd) begin
            case (sfr_sel)
                SFR_CTL: sfr_rdata_r <= ctl_view;
                SFR_PAGE: sfr_rdata_r <= {8'h00, page_r};
                default: sfr_rdata_r <= 16'h0000;
            endcase
        end
    end

    assign sfr_rdata = sfr_rdata_r;

    // ----------------------------------------------------------------
    // Table access: two-cycle read or latch write
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tcnt_r <= 2'h0;
            tgt_r <= 24'h000000;
            t_wr_r <= 1'b0;
            t_high_r <= 1'b0;
            t_byte_r <= 1'b0;
            t_wdata_r <= 16'h0000;
        end else if (tbl_take) begin
            tcnt_r <= 2'h1;
            tgt_r <= {page_r, tbl_ea};
            t_wr_r <= tbl_write;
            t_high_r <= tbl_high;
            t_byte_r <= tbl_byte;
            t_wdata_r <= tbl_wdata;
        end else if (tbl_end) begin
            tcnt_r <= 2'h0;
        end else if (tcnt_r != 2'h0) begin
            tcnt_r <= tcnt_r + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tbl_done_r <= 1'b0;
            tbl_rdata_r <= 16'h0000;
        end else begin
            tbl_done_r <= tbl_end;
            if (tbl_end && !t_wr_r) begin
                if (!t_high_r) begin
                    tbl_rdata_r <= t_byte_r ? {8'h00, tgt_r[0] ? fl_rdata[15:8] : fl_rdata[7:0]}
                                            : fl_rdata[15:0];
                end else begin
                    tbl_rdata_r <= (t_byte_r && tgt_r[0]) ? 16'h0000
                                                          : {8'h00, fl_rdata[23:16]};
                end
            end
        end
    end

    // Base address follows the latest latch write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            base_r <= 24'h000000;
        end else if (tbl_end && t_wr_r && !tgt_r[16+CFG_PAGE_BIT]) begin
            base_r <= tgt_r;
        end
    end

    assign tbl_done = tbl_done_r;
    assign tbl_rdata = tbl_rdata_r;
    assign fl_raddr = tgt_r;

    // Latch writes never touch the array; config-space writes dropped
    assign lat.wr_en = tbl_end && t_wr_r && !tgt_r[16+CFG_PAGE_BIT];
    assign lat.wr_idx = tgt_r[IDX_LSB +: IDX_W];
    assign lat.wr_be = lane_mask(t_high_r, t_byte_r, tgt_r[0]);
    assign lat.wr_data = t_high_r ? {t_wdata_r[7:0], 16'h0000}
                                  : {8'h00, t_byte_r ? {2{t_wdata_r[7:0]}} : t_wdata_r};

    // ----------------------------------------------------------------
    // Operation sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            cmd_r <= FCMD_NONE;
            idx_r <= 6'h00;
            idx_last_r <= 6'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start_try && key_ok && start_cmd != FCMD_NONE) begin
                        cmd_r <= start_cmd;
                        if (op_r == OP_ROW_PROG) begin
                            state_r <= ST_ROW;
                            idx_r <= 6'h00;
                            idx_last_r <= 6'(ROW_WORDS - 1);
                        end else begin
                            state_r <= ST_SINGLE;
                            idx_r <= base_r[IDX_LSB +: IDX_W];
                            idx_last_r <= base_r[IDX_LSB +: IDX_W];
                        end
                    end
                end
                ST_SINGLE: begin
                    if (fl_ack) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_ROW: begin
                    if (fl_ack) begin
                        if (idx_r == idx_last_r) begin
                            state_r <= ST_IDLE;
                        end else begin
                            idx_r <= idx_r + 6'h01;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign lat.rd_idx = idx_r;
    assign fl_req = (state_r != ST_IDLE);
    assign fl_cmd = fl_req ? cmd_r : FCMD_NONE;
    assign fl_wdata = lat.rd_data;

    always_comb begin
        case (cmd_r)
            FCMD_PAGE_ERASE: fl_addr = {base_r[ADDR_W-1:BLOCK_ALIGN_LSB],
                                        {BLOCK_ALIGN_LSB{1'b0}}};
            FCMD_BULK_ERASE: fl_addr = 24'h000000;
            default: fl_addr = {base_r[ADDR_W-1:ROW_ALIGN_LSB], idx_r, 1'b0};
        endcase
    end

endmodule : fsps_sequencer

// ### fsps_pkg.sv
package fsps_pkg;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int CTL_START_BIT = 15;
    localparam int CTL_OP_WRITE_ENABLE_BIT = 14;
    localparam int CTL_ERR_BIT = 13;
    localparam int CTL_ERASE_BIT = 6;
    localparam int CTL_OP_LSB = 0;
    localparam int CTL_OP_W = 4;
    localparam logic [15:0] CTL_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // Operation codes and unlock key
    // ----------------------------------------------------------------
    localparam logic [3:0] OP_BULK_ERASE = 4'hF;
    localparam logic [3:0] OP_WORD_PROG = 4'h3;
    localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
    localparam logic [3:0] OP_ROW_PROG = 4'h1;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // ----------------------------------------------------------------
    // Register selects on the special-function register port
    // ----------------------------------------------------------------
    localparam logic [1:0] SFR_CTL = 2'h0;
    localparam logic [1:0] SFR_KEY = 2'h1;
    localparam logic [1:0] SFR_PAGE = 2'h2;

    // ----------------------------------------------------------------
    // Geometry and timing
    // ----------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 24;
    localparam int ROW_WORDS = 64;
    localparam int IDX_W = 6;
    localparam int IDX_LSB = 1;
    localparam int ROW_ALIGN_LSB = 7;
    localparam int BLOCK_ALIGN_LSB = 10;
    localparam int CFG_PAGE_BIT = 7;
    localparam int TBL_CYCLES = 2;
    localparam logic [2:0] BE_NONE = 3'h0;
    localparam logic [2:0] BE_LOW_WORD = 3'h3;
    localparam logic [2:0] BE_BYTE0 = 3'h1;
    localparam logic [2:0] BE_BYTE1 = 3'h2;
    localparam logic [2:0] BE_BYTE2 = 3'h4;

    typedef enum logic [1:0] {
        FCMD_WORD_PROG = 2'b00,
        FCMD_PAGE_ERASE = 2'b01,
        FCMD_BULK_ERASE = 2'b10,
        FCMD_NONE = 2'b11
    } fsps_fcmd_t;

endpackage : fsps_pkg

// ### fsps_latch_if.sv
`timescale 1ns/10ps
interface fsps_latch_if;
    logic wr_en;
    logic [5:0] wr_idx;
    logic [2:0] wr_be;
    logic [23:0] wr_data;
    logic [5:0] rd_idx;
    logic [23:0] rd_data;
    modport seq (output wr_en, output wr_idx, output wr_be, output wr_data,
                 output rd_idx, input rd_data);
    modport buf_side (input wr_en, input wr_idx, input wr_be, input wr_data,
                      input rd_idx, output rd_data);
endinterface : fsps_latch_if

// ### fsps_latch_buf.sv
`timescale 1ns/10ps
module fsps_latch_buf (
    input wire logic clk,
    fsps_latch_if.buf_side lat
);
    import fsps_pkg::*;

    // ----------------------------------------------------------------
    // Row holding latches, no reset: contents start unknown
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] mem_r [ROW_WORDS];

    always_ff @(posedge clk) begin
        if (lat.wr_en) begin
            for (int b = 0; b < 3; b++) begin
                if (lat.wr_be[b]) begin
                    mem_r[lat.wr_idx][b*8 +: 8] <= lat.wr_data[b*8 +: 8];
                end
            end
        end
    end

    assign lat.rd_data = mem_r[lat.rd_idx];

endmodule : fsps_latch_buf

// ### fsps_props.sv
`timescale 1ns/10ps
module fsps_checker
    import fsps_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic soft_rstn,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [1:0] sfr_sel,
    input wire logic [1:0] sfr_be,
    input wire logic [15:0] sfr_wdata,
    input wire logic [15:0] sfr_rdata,
    input wire logic tbl_req,
    input wire logic tbl_done,
    input wire logic fl_req,
    input wire logic [23:0] fl_addr,
    input wire logic fl_ack,
    input wire logic cpu_stall
);
    // ----------------------------------------------------------------
    // Unlock progress seen on the register port
    // ----------------------------------------------------------------
    logic [1:0] key_r;
    logic op_ok;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            key_r <= 2'h0;
        end else if (!soft_rstn || tbl_req) begin
            key_r <= 2'h0;
        end else if (sfr_wr) begin
            key_r <= (sfr_sel != SFR_KEY || !sfr_be[0]) ? 2'h0 :
                (sfr_wdata[7:0] == KEY_FIRST) ? 2'h1 :
                (sfr_wdata[7:0] == KEY_SECOND && key_r == 2'h1) ? 2'h2 : 2'h0;
        end
    end
    assign op_ok = sfr_wdata[6:0] inside {7'h01, 7'h03, 7'h42};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    sequence s_ctl_start;
        sfr_wr && sfr_sel == SFR_CTL && sfr_be[1] && sfr_wdata[CTL_START_BIT] && !cpu_stall;
    endsequence
    sequence s_unlocked_ok;
        key_r == 2'h2 && sfr_wdata[CTL_OP_WRITE_ENABLE_BIT];
    endsequence
    property p_go;
        s_ctl_start ##0 (s_unlocked_ok ##0 op_ok) |=> cpu_stall && fl_req;
    endproperty
    a_go: assert property (p_go) else $error("valid start did not launch");
    property p_bad;
        s_ctl_start ##0 (key_r != 2'h2 || !sfr_wdata[CTL_OP_WRITE_ENABLE_BIT]) |=> !cpu_stall [*2];
    endproperty
    a_bad: assert property (p_bad) else $error("locked start ran");
    property p_nop;
        s_ctl_start ##0 (s_unlocked_ok ##0 !op_ok && sfr_wdata[6:0] != 7'h4F) |=> !fl_req;
    endproperty
    a_nop: assert property (p_nop) else $error("undefined code ran");
    property p_done_lat;
        tbl_done |-> $past(tbl_req, 3) ##1 !tbl_done;
    endproperty
    a_done_lat: assert property (p_done_lat) else $error("table done timing");
    property p_ro_zero;
        sfr_rd && sfr_sel == SFR_CTL |=> sfr_rdata[12:7] == 6'h00 && sfr_rdata[5:4] == 2'h0;
    endproperty
    a_ro_zero: assert property (p_ro_zero) else $error("unused bits not zero");
    property p_key_rd;
        sfr_rd && sfr_sel == SFR_KEY |=> sfr_rdata == 16'h0000;
    endproperty
    a_key_rd: assert property (p_key_rd) else $error("key readable");
    property p_fell_ack;
        $fell(cpu_stall) |-> $past(fl_ack);
    endproperty
    a_fell_ack: assert property (p_fell_ack) else $error("stall ended early");
    property p_req_stall;
        fl_req |-> cpu_stall;
    endproperty
    a_req_stall: assert property (p_req_stall) else $error("core not stalled");
    property p_hold_addr;
        fl_req && !fl_ack |=> fl_req && $stable(fl_addr);
    endproperty
    a_hold_addr: assert property (p_hold_addr) else $error("operation dropped");
endmodule : fsps_checker

bind fsps_sequencer fsps_checker u_chk (.*);

// ### fsps_flash_model.sv
`timescale 1ns/10ps
module fsps_flash_model
    import fsps_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [23:0] fl_raddr,
    output logic [23:0] fl_rdata,
    input wire logic fl_req,
    input wire fsps_pkg::fsps_fcmd_t fl_cmd,
    input wire logic [23:0] fl_addr,
    input wire logic [23:0] fl_wdata,
    input wire logic [3:0] ack_wait,
    output logic fl_ack
);
    // ----------------------------------------------------------------
    // Sparse array, erased words read all ones
    // ----------------------------------------------------------------
    logic [23:0] mem [logic [23:0]];
    logic [3:0] wait_r;
    function automatic logic [23:0] peek(input logic [23:0] a);
        return mem.exists({a[23:1], 1'b0}) ? mem[{a[23:1], 1'b0}] : 24'hFFFFFF;
    endfunction : peek
    always @(posedge clk) begin
        fl_rdata <= peek(fl_raddr);
    end
    // Programming only clears bits, like real cells
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fl_ack <= 1'b0;
            wait_r <= 4'h0;
        end else if (fl_ack || !fl_req) begin
            fl_ack <= 1'b0;
            wait_r <= 4'h0;
        end else if (wait_r < ack_wait) begin
            wait_r <= wait_r + 4'h1;
        end else begin
            fl_ack <= 1'b1;
            case (fl_cmd)
                FCMD_WORD_PROG: mem[{fl_addr[23:1], 1'b0}] = fl_wdata & peek(fl_addr);
                FCMD_PAGE_ERASE: for (int i = 0; i < 1024; i += 2) begin
                    mem.delete({fl_addr[23:10], 10'h000} + 24'(i));
                end
                FCMD_BULK_ERASE: mem.delete();
                default: ;
            endcase
        end
    end
endmodule : fsps_flash_model

// ### fsps_sequencer_tb.sv
`timescale 1ns/10ps
module fsps_sequencer_tb;
    import fsps_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, soft_rstn = 1'b1, serial_prog_mode = 1'b0;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, tbl_req = 1'b0, tbl_write = 1'b0;
    logic tbl_high = 1'b0, tbl_byte = 1'b0, fl_ack, fl_req, tbl_done, cpu_stall;
    logic [1:0] sfr_sel = 2'h0, sfr_be = 2'h3;
    logic [15:0] sfr_wdata = 16'h0000, tbl_ea = 16'h0000, tbl_wdata = 16'h0000;
    logic [15:0] sfr_rdata, tbl_rdata, rd_v;
    logic [23:0] fl_raddr, fl_rdata, fl_addr, fl_wdata;
    logic [3:0] ack_wait = 4'h0;
    fsps_fcmd_t fl_cmd;
    logic [15:0] nops [7] = '{16'hC043, 16'hC041, 16'hC002, 16'hC00F, 16'hC04F,
        16'hC005, 16'hC000};
    int fail_count = 0;
    int checks_done = 0;

    always #2.5 clk = ~clk;

    fsps_sequencer dut (.clk(clk), .resetn(resetn), .soft_rstn(soft_rstn),
        .serial_prog_mode(serial_prog_mode), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_sel(sfr_sel), .sfr_be(sfr_be), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .tbl_req(tbl_req), .tbl_write(tbl_write), .tbl_high(tbl_high), .tbl_byte(tbl_byte),
        .tbl_ea(tbl_ea), .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata), .tbl_done(tbl_done),
        .fl_raddr(fl_raddr), .fl_rdata(fl_rdata), .fl_req(fl_req), .fl_cmd(fl_cmd),
        .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_ack(fl_ack), .cpu_stall(cpu_stall));
    fsps_flash_model u_flash (.clk(clk), .resetn(resetn), .fl_raddr(fl_raddr),
        .fl_rdata(fl_rdata), .fl_req(fl_req), .fl_cmd(fl_cmd), .fl_addr(fl_addr),
        .fl_wdata(fl_wdata), .ack_wait(ack_wait), .fl_ack(fl_ack));

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic sfr_write(input logic [1:0] sel, input logic [15:0] d);
        @(negedge clk);
        sfr_wr = 1'b1;
        sfr_sel = sel;
        sfr_wdata = d;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask : sfr_write
    task automatic sfr_read(input logic [1:0] sel, output logic [15:0] d);
        @(negedge clk);
        sfr_rd = 1'b1;
        sfr_sel = sel;
        @(negedge clk);
        sfr_rd = 1'b0;
        @(negedge clk);
        d = sfr_rdata;
    endtask : sfr_read
    task automatic tbl(input logic wr, input logic hi, input logic byt, input logic [15:0] ea,
        input logic [15:0] wd, output logic [15:0] d);
        int n;
        @(negedge clk);
        tbl_req = 1'b1;
        tbl_write = wr;
        tbl_high = hi;
        tbl_byte = byt;
        tbl_ea = ea;
        tbl_wdata = wd;
        @(negedge clk);
        tbl_req = 1'b0;
        n = 1;
        while (tbl_done !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("tbl_latency", 16'(n), 16'h0003);
        d = tbl_rdata;
    endtask : tbl
    task automatic unlock_start(input logic [15:0] ctl, input logic runs);
        int n;
        sfr_write(SFR_CTL, ctl & 16'h7FFF);
        @(negedge clk);
        sfr_wr = 1'b1;
        sfr_sel = SFR_KEY;
        sfr_wdata = 16'h0055;
        @(negedge clk);
        sfr_wdata = 16'h00AA;
        @(negedge clk);
        sfr_sel = SFR_CTL;
        sfr_wdata = ctl;
        @(negedge clk);
        sfr_wr = 1'b0;
        check("stall", {15'h0, cpu_stall}, {15'h0, runs});
        n = 0;
        while (cpu_stall !== 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        check("finished", {15'h0, cpu_stall}, 16'h0000);
        repeat (2) @(negedge clk);
    endtask : unlock_start
    task automatic results;
        $display("Checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        #100000;
        fail_count++;
        results();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        sfr_read(SFR_CTL, rd_v);
        check("ctl_reset", rd_v, CTL_RESET);
        sfr_read(SFR_KEY, rd_v);
        check("key_read", rd_v, 16'h0000);
        sfr_write(SFR_CTL, 16'h7FFF);
        sfr_read(SFR_CTL, rd_v);
        check("ctl_mask", rd_v, 16'h404F);
        sfr_write(SFR_CTL, 16'h0003);
        unlock_start(16'h8003, 1'b0);
        sfr_read(SFR_CTL, rd_v);
        check("err_op_write_enable", rd_v, 16'h2003);
        sfr_write(SFR_CTL, 16'hC003);
        sfr_read(SFR_CTL, rd_v);
        check("err_nokey", rd_v, 16'h6003);
        // Word program, config write must be dropped
        sfr_write(SFR_PAGE, 16'h0001);
        tbl(1'b1, 1'b0, 1'b0, 16'h0A02, 16'h1234, rd_v);
        tbl(1'b1, 1'b1, 1'b0, 16'h0A02, 16'h0056, rd_v);
        sfr_write(SFR_PAGE, 16'h0081);
        tbl(1'b1, 1'b0, 1'b0, 16'h0A02, 16'h9999, rd_v);
        sfr_write(SFR_PAGE, 16'h0001);
        tbl(1'b0, 1'b0, 1'b0, 16'h0A02, 16'h0000, rd_v);
        check("latch_only", rd_v, 16'hFFFF);
        unlock_start(16'hC003, 1'b1);
        sfr_read(SFR_CTL, rd_v);
        check("ctl_after_word", rd_v, 16'h4003);
        tbl(1'b0, 1'b0, 1'b0, 16'h0A02, 16'h0000, rd_v);
        check("word_low", rd_v, 16'h1234);
        tbl(1'b0, 1'b1, 1'b0, 16'h0A02, 16'h0000, rd_v);
        check("word_high", rd_v, 16'h0056);
        tbl(1'b0, 1'b0, 1'b1, 16'h0A03, 16'h0000, rd_v);
        check("byte_low", rd_v, 16'h0012);
        tbl(1'b0, 1'b1, 1'b1, 16'h0A03, 16'h0000, rd_v);
        check("byte_phantom", rd_v, 16'h0000);
        // Row program, reverse order, one rewrite, slow array
        sfr_write(SFR_PAGE, 16'h0002);
        ack_wait = 4'h3;
        for (int i = 63; i >= 0; i--) begin
            tbl(1'b1, 1'b0, 1'b0, 16'h0100 + 16'(2 * i), 16'hA500 | 16'(i), rd_v);
            tbl(1'b1, 1'b1, 1'b0, 16'h0100 + 16'(2 * i), 16'(i), rd_v);
        end
        tbl(1'b1, 1'b0, 1'b0, 16'h010A, 16'hBEEF, rd_v);
        unlock_start(16'hC001, 1'b1);
        foreach (nops[k]) begin
            tbl(1'b0, 1'b0, 1'b0, 16'h0100 + 16'(20 * k), 16'h0000, rd_v);
            check("row_low", rd_v, k == 0 ? 16'hA500 : 16'hA500 | 16'(10 * k));
        end
        tbl(1'b0, 1'b0, 1'b0, 16'h010A, 16'h0000, rd_v);
        check("row_rewrite", rd_v, 16'hBEEF);
        tbl(1'b0, 1'b1, 1'b0, 16'h017E, 16'h0000, rd_v);
        check("row_last", rd_v, 16'h003F);
        // Page erase after dummy latch write in the block
        ack_wait = 4'h1;
        tbl(1'b1, 1'b0, 1'b0, 16'h0140, 16'h0000, rd_v);
        unlock_start(16'hC042, 1'b1);
        tbl(1'b0, 1'b1, 1'b0, 16'h017E, 16'h0000, rd_v);
        check("erased", rd_v, 16'h00FF);
        foreach (nops[k]) begin
            unlock_start(nops[k], 1'b0);
            sfr_read(SFR_CTL, rd_v);
            check("no_op", rd_v, nops[k] & 16'h404F);
        end
        serial_prog_mode = 1'b1;
        unlock_start(16'hC04F, 1'b1);
        sfr_write(SFR_PAGE, 16'h0001);
        tbl(1'b0, 1'b0, 1'b0, 16'h0A02, 16'h0000, rd_v);
        check("bulk", rd_v, 16'hFFFF);
        // Other reset sources keep control bits
        sfr_write(SFR_CTL, 16'h8001);
        @(negedge clk);
        soft_rstn = 1'b0;
        @(negedge clk);
        soft_rstn = 1'b1;
        sfr_read(SFR_CTL, rd_v);
        check("soft_keep", rd_v, 16'h2001);
        results();
    end
endmodule : fsps_sequencer_tb
